// ### logic/prs_regs.svh
// Register map, field positions, reset values and timing counts.
// Assumes a 20 MHz clock and byte addresses on the register bus.
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH

// ==========================================
// Timing
`define PRS_CLK_MHZ 20
`define PRS_US_CYCLES (`PRS_CLK_MHZ * 1)
`define PRS_LEAD_FIRST_MS 1
`define PRS_LEAD_FIRST_US (`PRS_LEAD_FIRST_MS * 1000)
`define PRS_LEAD_NEXT_US 20
`define PRS_WIDTH_MIN_US 4'h1
`define PRS_WIDTH_MAX_US 4'hA

// ==========================================
// Offsets
`define PRS_OFS_CTRL 8'h00
`define PRS_OFS_STATUS 8'h04
`define PRS_OFS_FRAME 8'h08
`define PRS_OFS_PERIOD 8'h0C
`define PRS_OFS_WIDTH 8'h10
`define PRS_OFS_SAMPLES 8'h14
`define PRS_OFS_SKIP 8'h18
`define PRS_OFS_SHDLY 8'h1C
`define PRS_OFS_SHWID 8'h20

// ==========================================
// Fields
`define PRS_CTRL_RUN 0
`define PRS_CTRL_AMP1 1
`define PRS_CTRL_AMP2 2
`define PRS_STAT_BUSY 0
`define PRS_STAT_OVERRUN 1

// ==========================================
// Reset values
`define PRS_RST_FRAME 24'h00_C350
`define PRS_RST_PERIOD 16'h0064
`define PRS_RST_WIDTH 4'h5
`define PRS_RST_SAMPLES 8'h20
`define PRS_RST_SKIP 8'h04
`define PRS_RST_SHDLY 4'h2
`define PRS_RST_SHWID 4'h2

`endif

// ### logic/prs_pkg.sv
// Types shared by the radar pulse sequencer.
// Assumes nothing beyond the register header.
package prs_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_PULSE, ST_GAP} prs_state_t;

    typedef struct packed {
        logic [15:0] period;
        logic [3:0] width;
        logic [7:0] samples;
        logic [7:0] skip;
        logic [3:0] shDelay;
        logic [3:0] shWidth;
    } prs_cfg_t;
endpackage

// ### logic/prs_timer_if.sv
// Control link between the sequencer and its frame timer.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface prs_timer_if;
    logic start;
    logic stop;
    logic tick;
    logic [23:0] period;
    logic fire;
    logic running;

    modport ctl (output start, stop, tick, period, input fire, running);
    modport tmr (input start, stop, tick, period, output fire, running);
endinterface

// ### logic/prs_frame_timer.sv
// Periodic frame timer counting microsecond ticks.
// Assumes the tick is a one-cycle enable from the sequencer.
`timescale 1ns/1ps
module prs_frame_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control link
    prs_timer_if.tmr tmr
);
    logic [23:0] count;
    logic run;
    // A zero period behaves as one tick
    wire logic lastTick = run & tmr.tick & (count <= 24'h00_0001);

    assign tmr.fire = lastTick;
    assign tmr.running = run;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= 24'h00_0000;
            run <= 1'b0;
        end else if (tmr.stop) begin
            run <= 1'b0;
        end else if (tmr.start) begin
            run <= 1'b1;
            count <= tmr.period;
        end else if (lastTick) begin
            count <= tmr.period;
        end else if (run & tmr.tick) begin
            count <= count - 24'h00_0001;
        end
    end
endmodule

// ### logic/prs_sequencer.sv
// Pulse sequencer for a pulsed Doppler radar front end, Avalon-MM slave.
// Assumes a 20 MHz clk and a front end that follows the outputs directly.
// Function
// - Frame starts only on frame timer fire
// - Pulses per frame equal samples plus skip
// - Supply and transmit enable only during pulse
// - Reference enables lead first pulse by 1 ms
// - Reference enables lead later pulses by 20 us
// - Reference enables off during pulse and elsewhere
// - Reference charge window directly precedes each pulse
// - Baseband hold switch briefly inside each pulse
// - Two static amplifier stage enables
// - Front-end supply enable is active low
// - Pulse width programmable 1 to 10 us
// - Off-time after pulse series until next frame
// - Sampling trigger issued with each pulse
// - Skip pulses come first in the frame
//
// Design decisions made here: the address map and register access over Avalon-MM.
`include "prs_regs.svh"
`timescale 1ns/1ps
module prs_sequencer #(
    parameter int LEAD_FIRST_US = `PRS_LEAD_FIRST_US
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Front end
    output logic frontendSupplyEnable_n,
    output logic txEnable,
    output logic referenceSupplyEnable,
    output logic referenceHoldSwitchEnable,
    output logic basebandHoldSwitchEnable,
    output logic ampStage1Enable,
    output logic ampStage2Enable,
    // Converter
    output logic sampleTrigger,
    output logic sampleDiscard
);
    localparam int US_CYCLES = `PRS_US_CYCLES;
    localparam int LEAD_FIRST_CYC = LEAD_FIRST_US * US_CYCLES;
    localparam int LEAD_NEXT_CYC = `PRS_LEAD_NEXT_US * US_CYCLES;

    // ==========================================
    // Register bus
    logic ack;
    logic ctrlRun;
    logic [23:0] framePeriod;
    logic [15:0] pulsePeriod;
    logic [3:0] pulseWidth;
    logic [7:0] sampleCount;
    logic [7:0] skipCount;
    logic [3:0] shDelay;
    logic [3:0] shWidth;
    logic overrun;
    logic [7:0] frameCount;
    prs_pkg::prs_state_t state;
    prs_pkg::prs_state_t next_state;
    prs_pkg::prs_cfg_t cfg;
    logic [15:0] phaseUs;
    logic [15:0] next_phaseUs;
    logic [8:0] pulseIdx;
    logic first;
    logic [4:0] usDiv;
    prs_timer_if frameTmr ();

    wire logic reqOn = read | write;
    wire logic wrTake = write & ack;
    wire logic isCtrl = address == `PRS_OFS_CTRL;
    wire logic isStatus = address == `PRS_OFS_STATUS;
    wire logic isFrame = address == `PRS_OFS_FRAME;
    wire logic isPeriod = address == `PRS_OFS_PERIOD;
    wire logic isWidth = address == `PRS_OFS_WIDTH;
    wire logic isSamples = address == `PRS_OFS_SAMPLES;
    wire logic isSkip = address == `PRS_OFS_SKIP;
    wire logic isShDly = address == `PRS_OFS_SHDLY;
    wire logic isShWid = address == `PRS_OFS_SHWID;
    wire logic busy = state != prs_pkg::ST_IDLE;
    wire logic [31:0] statusWord = {7'h00, pulseIdx, frameCount, 6'h00,
        overrun, busy};
    wire logic [31:0] ctrlWord = {29'h0000_0000, ampStage2Enable,
        ampStage1Enable, ctrlRun};
    // Unmapped offsets read as zero and ignore writes
    wire logic [31:0] rdWord =
        isCtrl ? ctrlWord :
        isStatus ? statusWord :
        isFrame ? {8'h00, framePeriod} :
        isPeriod ? {16'h0000, pulsePeriod} :
        isWidth ? {28'h000_0000, pulseWidth} :
        isSamples ? {24'h00_0000, sampleCount} :
        isSkip ? {24'h00_0000, skipCount} :
        isShDly ? {28'h000_0000, shDelay} :
        isShWid ? {28'h000_0000, shWidth} : 32'h0000_0000;
    // Byte lanes left out keep their stored value
    wire logic [31:0] wrWord = {
        byteenable[3] ? writedata[31:24] : rdWord[31:24],
        byteenable[2] ? writedata[23:16] : rdWord[23:16],
        byteenable[1] ? writedata[15:8] : rdWord[15:8],
        byteenable[0] ? writedata[7:0] : rdWord[7:0]};
    wire logic ovClear = wrTake & isStatus & byteenable[0] &
        writedata[`PRS_STAT_OVERRUN];

    // One wait cycle per access
    assign waitrequest = reqOn & !ack;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack <= 1'b0;
            readdata <= 32'h0000_0000;
        end else begin
            ack <= reqOn & !ack;
            readdata <= (read & !ack) ? rdWord : readdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrlRun <= 1'b0;
            ampStage1Enable <= 1'b0;
            ampStage2Enable <= 1'b0;
            framePeriod <= `PRS_RST_FRAME;
            pulsePeriod <= `PRS_RST_PERIOD;
            pulseWidth <= `PRS_RST_WIDTH;
            sampleCount <= `PRS_RST_SAMPLES;
            skipCount <= `PRS_RST_SKIP;
            shDelay <= `PRS_RST_SHDLY;
            shWidth <= `PRS_RST_SHWID;
        end else if (wrTake) begin
            if (isCtrl) begin
                ctrlRun <= wrWord[`PRS_CTRL_RUN];
                ampStage1Enable <= wrWord[`PRS_CTRL_AMP1];
                ampStage2Enable <= wrWord[`PRS_CTRL_AMP2];
            end
            if (isFrame) framePeriod <= wrWord[23:0];
            if (isPeriod) pulsePeriod <= wrWord[15:0];
            if (isWidth) pulseWidth <= wrWord[3:0];
            if (isSamples) sampleCount <= wrWord[7:0];
            if (isSkip) skipCount <= wrWord[7:0];
            if (isShDly) shDelay <= wrWord[3:0];
            if (isShWid) shWidth <= wrWord[3:0];
        end
    end

    // ==========================================
    // Microsecond tick and frame timer
    wire logic usTick = usDiv == 5'(US_CYCLES - 1);

    always_ff @(posedge clk) begin
        if (!rst_n) usDiv <= 5'h00;
        else usDiv <= usTick ? 5'h00 : usDiv + 5'h01;
    end

    assign frameTmr.start = ctrlRun & !frameTmr.running;
    assign frameTmr.stop = !ctrlRun;
    assign frameTmr.tick = usTick;
    assign frameTmr.period = framePeriod;

    prs_frame_timer frameTimer (
        .clk(clk),
        .rst_n(rst_n),
        .tmr(frameTmr)
    );

    // ==========================================
    // Pulse sequence
    wire logic [8:0] liveTotal = {1'b0, sampleCount} + {1'b0, skipCount};
    wire logic [8:0] cfgTotal = {1'b0, cfg.samples} + {1'b0, cfg.skip};
    // No frame while idle between trains unless the timer fires
    wire logic frameStart = frameTmr.fire & !busy &
        (liveTotal != 9'h000);
    wire logic [3:0] widthClamp =
        (pulseWidth < `PRS_WIDTH_MIN_US) ? `PRS_WIDTH_MIN_US :
        (pulseWidth > `PRS_WIDTH_MAX_US) ? `PRS_WIDTH_MAX_US : pulseWidth;
    // Too short a pulse period drops the gap, never the lead
    wire logic [16:0] gapFull = {1'b0, cfg.period} - {13'h0000, cfg.width} -
        17'(`PRS_LEAD_NEXT_US);
    wire logic noGap = gapFull[16] | (gapFull == 17'h0_0000);
    wire logic [15:0] phaseLen =
        (state == prs_pkg::ST_LEAD) ?
            (first ? 16'(LEAD_FIRST_US) : 16'(`PRS_LEAD_NEXT_US)) :
        (state == prs_pkg::ST_PULSE) ? {12'h000, cfg.width} : gapFull[15:0];
    wire logic phaseEnd = usTick & (phaseUs == phaseLen - 16'h0001);
    wire logic lastPulse = pulseIdx == cfgTotal - 9'h001;

    always_comb begin
        next_state = state;
        unique case (state)
            prs_pkg::ST_IDLE: if (frameStart) next_state = prs_pkg::ST_LEAD;
            prs_pkg::ST_LEAD: if (phaseEnd) next_state = prs_pkg::ST_PULSE;
            prs_pkg::ST_PULSE: begin
                if (phaseEnd) begin
                    next_state = lastPulse ? prs_pkg::ST_IDLE :
                        noGap ? prs_pkg::ST_LEAD : prs_pkg::ST_GAP;
                end
            end
            prs_pkg::ST_GAP: if (phaseEnd) next_state = prs_pkg::ST_LEAD;
        endcase
        if (!ctrlRun) next_state = prs_pkg::ST_IDLE;
        next_phaseUs = (next_state != state || next_state == prs_pkg::ST_IDLE)
            ? 16'h0000 : usTick ? phaseUs + 16'h0001 : phaseUs;
    end

    wire logic next_pulse = next_state == prs_pkg::ST_PULSE;
    wire logic next_lead = next_state == prs_pkg::ST_LEAD;
    wire logic [15:0] shStart = {12'h000, cfg.shDelay};
    wire logic [15:0] shStop = shStart + {12'h000, cfg.shWidth};
    wire logic next_bbHold = next_pulse & (next_phaseUs >= shStart) &
        (next_phaseUs < shStop);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= prs_pkg::ST_IDLE;
            phaseUs <= 16'h0000;
            pulseIdx <= 9'h000;
            first <= 1'b0;
            overrun <= 1'b0;
            frameCount <= 8'h00;
            cfg <= '0;
        end else begin
            state <= next_state;
            phaseUs <= next_phaseUs;
            // Event wins over a clear in the same cycle
            overrun <= (frameTmr.fire & busy) | (overrun & !ovClear);
            if (frameStart) begin
                cfg <= {pulsePeriod, widthClamp, sampleCount, skipCount,
                    shDelay, shWidth};
                first <= 1'b1;
                pulseIdx <= 9'h000;
                frameCount <= frameCount + 8'h01;
            end else if (state == prs_pkg::ST_PULSE && phaseEnd) begin
                first <= 1'b0;
                pulseIdx <= pulseIdx + 9'h001;
            end
        end
    end

    // ==========================================
    // Registered outputs, aligned with state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frontendSupplyEnable_n <= 1'b1;
            txEnable <= 1'b0;
            referenceSupplyEnable <= 1'b0;
            referenceHoldSwitchEnable <= 1'b0;
            basebandHoldSwitchEnable <= 1'b0;
            sampleTrigger <= 1'b0;
            sampleDiscard <= 1'b0;
        end else begin
            frontendSupplyEnable_n <= !next_pulse;
            txEnable <= next_pulse;
            referenceSupplyEnable <= next_lead;
            referenceHoldSwitchEnable <= next_lead;
            basebandHoldSwitchEnable <= next_bbHold;
            sampleTrigger <= next_pulse & (state != prs_pkg::ST_PULSE);
            sampleDiscard <= next_pulse & ({1'b0, cfg.skip} > pulseIdx);
        end
    end

    // ==========================================
    // Checks
    logic [15:0] refCycles;
    logic [7:0] txCycles;
    logic [8:0] pulseSeen;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            refCycles <= 16'h0000;
            txCycles <= 8'h00;
            pulseSeen <= 9'h000;
        end else begin
            refCycles <= referenceSupplyEnable ? refCycles + 16'h0001 : 16'h0000;
            txCycles <= txEnable ? txCycles + 8'h01 : 8'h00;
            pulseSeen <= frameStart ? 9'h000 :
                sampleTrigger ? pulseSeen + 9'h001 : pulseSeen;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence leadDone;
        $fell(referenceSupplyEnable) && $past(ctrlRun);
    endsequence
    sequence pulseDone;
        $fell(txEnable) && $past(ctrlRun);
    endsequence

    frame_start_a: assert property (
        $rose(busy) |-> $past(frameTmr.fire))
        else $error("frame began without timer fire");
    pulse_count_a: assert property (
        $fell(busy) && $past(ctrlRun) |-> pulseSeen == cfgTotal)
        else $error("wrong pulse count in frame");
    supply_only_pulse_a: assert property (
        txEnable == !frontendSupplyEnable_n &&
        (!txEnable || state == prs_pkg::ST_PULSE))
        else $error("supply or transmit outside pulse");
    lead_first_a: assert property (
        leadDone and first |-> refCycles == LEAD_FIRST_CYC)
        else $error("first lead time wrong");
    lead_next_a: assert property (
        leadDone and !first |-> refCycles == LEAD_NEXT_CYC)
        else $error("later lead time wrong");
    ref_quiet_a: assert property (
        referenceSupplyEnable |-> referenceHoldSwitchEnable && !txEnable &&
        state == prs_pkg::ST_LEAD)
        else $error("reference enables outside lead");
    charge_then_pulse_a: assert property (
        leadDone |-> !frontendSupplyEnable_n ##1 !frontendSupplyEnable_n)
        else $error("pulse does not follow charge");
    bb_in_pulse_a: assert property (
        basebandHoldSwitchEnable |-> txEnable && !$fell(txEnable))
        else $error("baseband hold outside pulse");
    amp_enable_a: assert property (
        wrTake && isCtrl && byteenable[0] |=>
        ampStage1Enable == $past(writedata[`PRS_CTRL_AMP1]) &&
        ampStage2Enable == $past(writedata[`PRS_CTRL_AMP2]))
        else $error("amplifier enables not written");
    pulse_width_a: assert property (
        pulseDone |-> txCycles == cfg.width * US_CYCLES &&
        cfg.width >= `PRS_WIDTH_MIN_US && cfg.width <= `PRS_WIDTH_MAX_US)
        else $error("pulse width wrong");
    trigger_a: assert property (
        $rose(txEnable) |-> sampleTrigger ##1 !sampleTrigger)
        else $error("sampling trigger missing");
    skip_first_a: assert property (
        txEnable |-> sampleDiscard == (pulseIdx < {1'b0, cfg.skip}))
        else $error("skip pulses misplaced");
    idle_quiet_a: assert property (
        !busy |-> frontendSupplyEnable_n && !referenceSupplyEnable &&
        !basebandHoldSwitchEnable && !sampleTrigger)
        else $error("outputs active while idle");
endmodule

// ### verif/prs_shield_model.sv
// Behavioural model of the analog front-end shield behind the sequencer.
// Assumes it sees the sequencer outputs on the same clk; it drives nothing.
`timescale 1ns/1ps
module prs_shield_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control lines from the sequencer
    input wire logic supplyEnable_n,
    input wire logic txEnable,
    input wire logic refSupply,
    input wire logic refHold,
    input wire logic bbHold,
    input wire logic trigger,
    input wire logic discard,
    // Measurements
    output logic [31:0] pulses,
    output logic [31:0] triggers,
    output logic [31:0] discards,
    output logic [31:0] violations,
    output logic [31:0] lastLead,
    output logic [31:0] lastWidth,
    output logic [31:0] lastSh,
    output logic [31:0] lastShOfs,
    output logic [31:0] lastPeriod
);
    logic prevOn, charged;
    logic [31:0] runLead, runWidth, runSh, cyc;
    // ==========================================
    // Line checks
    wire on = !supplyEnable_n;
    wire start = on && !prevOn;
    wire badTx = txEnable != on;
    wire badRef = (refSupply && on) || (refSupply != refHold);
    wire badBb = bbHold && !on;
    wire badTrig = trigger != start;
    wire badDisc = discard && !on;
    // Cap must be recharged before every pulse
    wire badCharge = start && !charged;
    wire bad = badTx || badRef || badBb || badTrig || badDisc || badCharge;
    // ==========================================
    // Measurement
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {prevOn, charged} <= 2'b00;
            {runLead, runWidth, runSh, cyc} <= '0;
            {pulses, triggers, discards, violations} <= '0;
            {lastLead, lastWidth, lastSh, lastShOfs, lastPeriod} <= '0;
        end else begin
            prevOn <= on;
            runLead <= refSupply ? runLead + 1 : 32'h0000_0000;
            runWidth <= on ? runWidth + 1 : 32'h0000_0000;
            runSh <= bbHold ? runSh + 1 : 32'h0000_0000;
            cyc <= start ? 32'h0000_0001 : cyc + 1;
            if (refSupply && refHold) charged <= 1'b1;
            if (start) begin
                pulses <= pulses + 1;
                lastLead <= runLead;
                lastPeriod <= cyc;
                charged <= 1'b0;
                if (discard) discards <= discards + 1;
            end
            if (trigger) triggers <= triggers + 1;
            if (on) lastWidth <= runWidth + 1;
            if (bbHold) lastSh <= runSh + 1;
            if (bbHold && runSh == 0) lastShOfs <= runWidth;
            if (bad) violations <= violations + 1;
        end
    end
endmodule

// ### verif/tb.sv
// Self-checking bench for the radar pulse sequencer.
// Assumes the shield model and a shortened first lead time.
`include "prs_regs.svh"
`timescale 1ns/1ps
module tb;
    localparam int LEAD = 30;
    logic clk, rst_n, read, write, waitrequest;
    logic [7:0] address;
    logic [31:0] writedata, readdata, q;
    logic supplyN, tx, refS, refH, bb, amp1, amp2, trig, disc;
    logic [8:0] outs;
    logic [31:0] pulses, triggers, discards, violations;
    logic [31:0] lastLead, lastWidth, lastSh, lastShOfs, lastPeriod;
    int mismatches, checks, cycles, t0, i;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d, e;} prs_row_t;
    prs_row_t rows[19];

    assign outs = {supplyN, tx, refS, refH, bb, trig, disc, amp1, amp2};

    prs_sequencer #(.LEAD_FIRST_US(LEAD)) i_dut (
        .clk(clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hF),
        .readdata(readdata), .waitrequest(waitrequest),
        .frontendSupplyEnable_n(supplyN), .txEnable(tx),
        .referenceSupplyEnable(refS), .referenceHoldSwitchEnable(refH),
        .basebandHoldSwitchEnable(bb), .ampStage1Enable(amp1),
        .ampStage2Enable(amp2), .sampleTrigger(trig), .sampleDiscard(disc));

    prs_shield_model i_shield (
        .clk(clk), .rst_n(rst_n), .supplyEnable_n(supplyN), .txEnable(tx),
        .refSupply(refS), .refHold(refH), .bbHold(bb), .trigger(trig),
        .discard(disc), .pulses(pulses), .triggers(triggers),
        .discards(discards), .violations(violations), .lastLead(lastLead),
        .lastWidth(lastWidth), .lastSh(lastSh), .lastShOfs(lastShOfs),
        .lastPeriod(lastPeriod));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Hang guard, well above the two frames the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            wrap_up();
        end
    end

    // ==========================================
    // Helpers
    task check(input string name, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        // Request stands until waitrequest is seen low at an edge
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task wait_tx(input logic v);
        int n;
        n = 0;
        while (txEnable_seen() !== v && n < 20000) begin
            @(negedge clk);
            n++;
        end
        if (n == 20000) mismatches++;
    endtask

    function logic txEnable_seen();
        return tx;
    endfunction

    task wrap_up();
        $display("checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        {rst_n, read, write, address, writedata} = '0;
        {cycles, mismatches, checks} = '0;
        rows = '{
            '{1'b0, `PRS_OFS_CTRL, 32'h0, 32'h0},
            '{1'b0, `PRS_OFS_STATUS, 32'h0, 32'h0},
            '{1'b0, `PRS_OFS_FRAME, 32'h0, {8'h00, `PRS_RST_FRAME}},
            '{1'b0, `PRS_OFS_PERIOD, 32'h0, {16'h0000, `PRS_RST_PERIOD}},
            '{1'b0, `PRS_OFS_WIDTH, 32'h0, {28'h000_0000, `PRS_RST_WIDTH}},
            '{1'b0, `PRS_OFS_SAMPLES, 32'h0, {24'h00_0000, `PRS_RST_SAMPLES}},
            '{1'b0, `PRS_OFS_SKIP, 32'h0, {24'h00_0000, `PRS_RST_SKIP}},
            '{1'b0, `PRS_OFS_SHDLY, 32'h0, {28'h000_0000, `PRS_RST_SHDLY}},
            '{1'b0, `PRS_OFS_SHWID, 32'h0, {28'h000_0000, `PRS_RST_SHWID}},
            '{1'b0, 8'h24, 32'h0, 32'h0},
            '{1'b1, 8'h24, 32'hFFFF_FFFF, 32'h0},
            '{1'b1, `PRS_OFS_STATUS, 32'hFFFF_FFFF, 32'h0},
            '{1'b1, `PRS_OFS_FRAME, 32'h0000_012C, 32'h0000_012C},
            '{1'b1, `PRS_OFS_PERIOD, 32'h0000_0028, 32'h0000_0028},
            '{1'b1, `PRS_OFS_WIDTH, 32'h0000_0003, 32'h0000_0003},
            '{1'b1, `PRS_OFS_SAMPLES, 32'h0000_0001, 32'h0000_0001},
            '{1'b1, `PRS_OFS_SKIP, 32'h0000_0002, 32'h0000_0002},
            '{1'b1, `PRS_OFS_SHDLY, 32'h0000_0001, 32'h0000_0001},
            '{1'b1, `PRS_OFS_SHWID, 32'h0000_0001, 32'h0000_0001}};
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("reset outputs", {23'h00_0000, outs}, 32'h0000_0100);
        @(posedge clk);
        rst_n <= 1'b1;
        $display("test reset done");
        for (i = 0; i < 19; i++) begin
            if (rows[i].wr) bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 32'h0);
            check($sformatf("register %h", rows[i].a), q, rows[i].e);
        end
        $display("test registers done");
        // Frame period 300 us, 1 sample plus 2 skips, 800-cycle period
        bus(1'b1, `PRS_OFS_CTRL, 32'h0000_0007);
        @(negedge clk);
        check("idle before fire", {23'h00_0000, outs}, 32'h0000_0103);
        check("amp enables", {30'h0, amp1, amp2}, 32'h0000_0003);
        wait_tx(1'b1);
        t0 = cycles;
        check("pulse trigger", {31'h0, trig}, 32'h0000_0001);
        wait_tx(1'b0);
        check("first lead", lastLead, LEAD * 20);
        check("pulse width", lastWidth, 32'h0000_003C);
        check("hold offset", lastShOfs, 32'h0000_0014);
        check("hold length", lastSh, 32'h0000_0014);
        // Mid-frame write must wait for the next frame
        bus(1'b1, `PRS_OFS_WIDTH, 32'h0000_000C);
        wait_tx(1'b1);
        wait_tx(1'b0);
        check("later lead", lastLead, 32'h0000_0190);
        check("pulse period", lastPeriod, 32'h0000_0320);
        check("width held", lastWidth, 32'h0000_003C);
        check("skip pulses", discards, 32'h0000_0002);
        wait_tx(1'b1);
        wait_tx(1'b0);
        check("discards total", discards, 32'h0000_0002);
        check("pulse count", pulses, 32'h0000_0003);
        check("trigger count", triggers, 32'h0000_0003);
        repeat (1000) @(negedge clk);
        check("off-time pulses", pulses, 32'h0000_0003);
        check("idle after frame", {23'h00_0000, outs}, 32'h0000_0103);
        bus(1'b0, `PRS_OFS_STATUS, 32'h0);
        check("status", q & 32'h0000_FF01, 32'h0000_0100);
        $display("test frame one done");
        wait_tx(1'b1);
        check("frame spacing", cycles - t0, 32'h0000_1770);
        wait_tx(1'b0);
        check("clamped width", lastWidth, 32'h0000_00C8);
        repeat (300) @(negedge clk);
        check("in lead", {30'h0, refS, refH}, 32'h0000_0003);
        $display("test frame two done");
        // Abort in the middle of a lead window
        bus(1'b1, `PRS_OFS_CTRL, 32'h0000_0006);
        repeat (2) @(negedge clk);
        check("abort outputs", {23'h00_0000, outs}, 32'h0000_0103);
        repeat (1000) @(negedge clk);
        check("no pulse after abort", pulses, 32'h0000_0004);
        $display("test abort done");
        // Frame period shorter than the train, so fires land while busy
        bus(1'b1, `PRS_OFS_FRAME, 32'h0000_0014);
        bus(1'b1, `PRS_OFS_CTRL, 32'h0000_0001);
        repeat (1200) @(negedge clk);
        bus(1'b0, `PRS_OFS_STATUS, 32'h0);
        check("overrun set", q & 32'h0000_0003, 32'h0000_0003);
        bus(1'b1, `PRS_OFS_CTRL, 32'h0000_0000);
        bus(1'b1, `PRS_OFS_STATUS, 32'h0000_0002);
        bus(1'b0, `PRS_OFS_STATUS, 32'h0);
        check("overrun cleared", q & 32'h0000_0003, 32'h0000_0000);
        check("line faults", violations, 32'h0000_0000);
        $display("test overrun done");
        wrap_up();
    end
endmodule
